// >>> verification/host_cmd_model.sv
/* Host controller model issuing position command moves.
   Assumes send is called just after a rising edge. */
module host_cmd_model (
   input wire clk_sys_i,
   output logic cmd_valid_o,
   output logic signed [31:0] cmd_delta_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      cmd_valid_o = 1'h0;
      cmd_delta_o = 32'h0;
   end
   // idle delta is scrambled so a stale value never looks valid
   task automatic send(input logic signed [31:0] d);
      cmd_valid_o = 1'h1;
      cmd_delta_o = d;
      @(posedge clk_sys_i);
      #1;
      cmd_valid_o = 1'h0;
      cmd_delta_o = ~d;
      @(posedge clk_sys_i);
      #1;
   endtask
endmodule

// >>> verification/soft_limit_checker.sv
/* Checker on the limit protection top ports.
   Assumes one clock and an async active-low reset. */
module soft_limit_checker (
   input wire clk_sys_i,
   input wire reset_n_i,
   input wire servo_on_i,
   input wire [3:0] control_mode_select_i,
   input wire [15:0] limit_margin_setting_i,
   input wire trial_run_i,
   input wire freq_measure_i,
   input wire motor_mismatch_i,
   input wire self_diag_fault_i,
   input wire range_exceeded_alarm_o,
   input wire [7:0] alarm_code_o,
   input wire alarm_o,
   input wire stop_req_o,
   input wire [1:0] stop_action_o,
   input wire protect_active_o
);
   wire mode_w = control_mode_select_i == 4'h0 ||
      control_mode_select_i == 4'h6;
   wire off_w = !servo_on_i || limit_margin_setting_i == 16'h0;
   wire sup_w = trial_run_i || freq_measure_i;
   // a fault only takes a code slot no other fault holds
   wire free_w = alarm_code_o == 8'h00 || alarm_code_o == 8'h22;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!reset_n_i);
   // two cycles of cause allow for the registered active flag
   a_mode_gate: assert property (
      !$past(mode_w) && !$past(mode_w, 2) |-> !protect_active_o)
      else $error("active in wrong mode");
   a_servo_gate: assert property (
      $past(off_w) && $past(off_w, 2) |-> !protect_active_o)
      else $error("active when off");
   a_trial_gate: assert property (
      $past(sup_w) && $past(sup_w, 2) |-> !protect_active_o)
      else $error("active when suppressed");
   a_stop_alarm: assert property (
      stop_req_o == alarm_o) else $error("stop differs from alarm");
   a_limit_code: assert property (
      alarm_code_o == 8'h22 |-> range_exceeded_alarm_o && alarm_o)
      else $error("limit code without trip");
   a_diag_code: assert property (
      $past(self_diag_fault_i, 2) && $past(free_w) |-> alarm_code_o == 8'hff)
      else $error("diag code missing");
   a_motor_code: assert property (
      $past(motor_mismatch_i && !self_diag_fault_i, 2) && $past(free_w)
      |-> alarm_code_o == 8'h5f) else $error("motor code missing");
   a_action_hold: assert property (
      alarm_o && $past(alarm_o) |-> $stable(stop_action_o))
      else $error("stop action moved in alarm");
endmodule

bind servo_software_limit_protection soft_limit_checker u_chk (.*);

// >>> verification/test_servo_software_limit_protection.sv
/* Self-checking bench for the soft limit protection.
   Assumes the host model alone drives the command port. */
module test_servo_software_limit_protection;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys_i = '0, reset_n_i = '0, servo_on_i = '0, trial_run_i = '0;
   logic freq_measure_i = '0, homing_done_i = '0, autotune_start_i = '0;
   logic autotune_end_i = '0, alarm_clear_i = '0, scale_unsupported_i = '0;
   logic motor_mismatch_i = '0, self_diag_fault_i = '0, cmd_valid_i;
   logic [3:0] control_mode_select_i = '0;
   logic [15:0] limit_margin_setting_i = '0;
   logic [1:0] error_response_action_i = '0, stop_action_o;
   logic signed [31:0] cmd_delta_i, motor_pos_i = '0;
   logic range_exceeded_alarm_o, alarm_o, stop_req_o, protect_active_o;
   logic protect_valid_o;
   logic [7:0] alarm_code_o;
   logic [7:0] codes[3] = '{8'hff, 8'h5f, 8'h5d};
   int miscompares = 0, comparisons = 0, seed = 43973;
   longint ref_m = 0, lo_m = 0, hi_m = 0, mg = 100, offs[$];
   bit sup = 0;
   servo_software_limit_protection u_servo_software_limit_protection (.*);
   host_cmd_model u_host_cmd_model (.clk_sys_i, .cmd_valid_o(cmd_valid_i),
      .cmd_delta_o(cmd_delta_i));
   always #5 clk_sys_i = ~clk_sys_i;
   initial begin
      #900000;
      miscompares++;
      close_out;
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic chk(input string n, input logic [7:0] e, g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   // model: trip when beyond recorded span plus margin
   function automatic logic outside(input longint p);
      return !sup && (p < ref_m + lo_m - mg || p > ref_m + hi_m + mg);
   endfunction
   task automatic clear_alarm;
      motor_pos_i = 32'(ref_m);
      alarm_clear_i = 1'h1;
      step(1);
      alarm_clear_i = 1'h0;
      step(3);
      chk("clear", 8'h0, alarm_o);
   endtask
   task automatic move(input longint off);
      motor_pos_i = 32'(ref_m + off);
      step(2);
      chk("trip", outside(ref_m + off), range_exceeded_alarm_o);
      chk("code", outside(ref_m + off) ? 8'h22 : 8'h0, alarm_code_o);
      chk("stop", outside(ref_m + off), stop_req_o);
      clear_alarm;
   endtask
   task automatic edges;
      offs = '{hi_m + mg, hi_m + mg + 1, lo_m - mg, lo_m - mg - 1};
      foreach (offs[i]) move(offs[i]);
   endtask
   task automatic close_out;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      error_response_action_i = 2'($random(seed));
      motor_pos_i = $random(seed) % 32'sd50000;
      step(16);
      reset_n_i = 1'h1;
      step(1);
      chk("valid", 8'h1, protect_valid_o);
      servo_on_i = 1'h1;
      limit_margin_setting_i = 16'h64;
      for (int m = 0; m < 16; m++) begin
         control_mode_select_i = 4'(m);
         step(4);
         chk("active", m == 0 || m == 6, protect_active_o);
      end
      control_mode_select_i = 4'h6;
      ref_m = motor_pos_i;
      step(4);
      edges;
      u_host_cmd_model.send(32'sh1f4);
      u_host_cmd_model.send(-32'sh320);
      hi_m = 500;
      lo_m = -300;
      edges;
      $display("range tests done");
      for (int k = 0; k < 2; k++) begin
         {trial_run_i, freq_measure_i} = 2'h2 >> k;
         sup = 1;
         step(3);
         move(hi_m + mg + 1);
         {trial_run_i, freq_measure_i} = 2'h0;
         sup = 0;
         step(3);
      end
      for (int k = 0; k < 2; k++) begin
         servo_on_i = k[0];
         limit_margin_setting_i = k[0] ? 16'h0 : 16'h64;
         u_host_cmd_model.send(32'sh3e8);
         chk("active", 8'h0, protect_active_o);
         servo_on_i = 1'h1;
         limit_margin_setting_i = 16'h64;
         lo_m = 0;
         hi_m = 0;
         step(4);
         edges;
      end
      $display("gate tests done");
      for (int k = 0; k < 3; k++) begin
         u_host_cmd_model.send(32'sh7fff_ffff);
         chk("valid", 8'h0, protect_valid_o);
         motor_pos_i = motor_pos_i - 32'sh10_0000;
         step(4);
         chk("trip", 8'h0, alarm_o);
         {homing_done_i, autotune_start_i, autotune_end_i} = 3'h4 >> k;
         step(1);
         {homing_done_i, autotune_start_i, autotune_end_i} = 3'h0;
         step(2);
         chk("valid", 8'h1, protect_valid_o);
         ref_m = motor_pos_i;
      end
      for (int i = 0; i < 8; i++) move($random(seed) % 160);
      $display("bound tests done");
      for (int k = 0; k < 3; k++) begin
         error_response_action_i = 2'(k);
         step(1);
         {self_diag_fault_i, motor_mismatch_i, scale_unsupported_i} =
            3'h4 >> k;
         step(1);
         {self_diag_fault_i, motor_mismatch_i, scale_unsupported_i} = 3'h0;
         step(2);
         chk("code", codes[k], alarm_code_o);
         chk("action", 8'(k), stop_action_o);
         clear_alarm;
      end
      $display("fault tests done");
      close_out;
   end
endmodule

// >>> verilog/fault_coder.v
/*
 * Driver protection code selection for the non-limit faults.
 * Assumes fault inputs are synchronous levels; codes latch until cleared.
 */
`include "soft_limit_regs.vh"

module fault_coder (
   input wire clk_sys_i,
   input wire reset_n_i,
   input wire alarm_clear_i,
   input wire scale_unsupported_i,
   input wire motor_mismatch_i,
   input wire self_diag_fault_i,
   output reg [`CODE_W-1:0] fault_code_o,
   output reg fault_o
);

   function [`CODE_W-1:0] pick_code;
      input scale;
      input motor;
      input diag;
      begin
         if (diag) begin
            pick_code = `CODE_OTHER;
         end else if (motor) begin
            pick_code = `CODE_MOTOR_MATCH;
         end else if (scale) begin
            pick_code = `CODE_SCALE_TYPE;
         end else begin
            pick_code = `CODE_NONE;
         end
      end
   endfunction

   wire any_fault;
   assign any_fault = scale_unsupported_i | motor_mismatch_i |
      self_diag_fault_i;

   // first fault wins; a live fault overrides the clear
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         fault_code_o <= `CODE_NONE;
         fault_o <= 1'b0;
      end else if (any_fault && !fault_o) begin
         fault_code_o <= pick_code(scale_unsupported_i, motor_mismatch_i,
            self_diag_fault_i);
         fault_o <= 1'b1;
      end else if (alarm_clear_i && !any_fault) begin
         fault_code_o <= `CODE_NONE;
         fault_o <= 1'b0;
      end
   end

endmodule

// >>> verilog/range_tracker.v
/*
 * Position command input range tracker: keeps the lowest and highest
 * commanded offset from the reference point since the last clearance.
 * Assumes the command delta is applied once per cycle when valid.
 */
`include "soft_limit_regs.vh"

module range_tracker (
   input wire clk_sys_i,
   input wire reset_n_i,
   input wire clear_i,
   input wire cmd_valid_i,
   input wire signed [`CNT_MSB:0] cmd_delta_i,
   output reg signed [`POS_MSB:0] cmd_pos_o,
   output reg signed [`POS_MSB:0] low_o,
   output reg signed [`POS_MSB:0] high_o
);

   wire signed [`POS_MSB:0] next_pos;

   // widened by two bits so an overshoot never wraps
   assign next_pos = cmd_pos_o + {{2{cmd_delta_i[`CNT_MSB]}}, cmd_delta_i};

   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cmd_pos_o <= `POS_ZERO;
         low_o <= `POS_ZERO;
         high_o <= `POS_ZERO;
      end else if (clear_i) begin
         cmd_pos_o <= `POS_ZERO;
         low_o <= `POS_ZERO;
         high_o <= `POS_ZERO;
      end else if (cmd_valid_i) begin
         cmd_pos_o <= next_pos;
         if (next_pos < low_o) begin
            low_o <= next_pos;
         end
         if (next_pos > high_o) begin
            high_o <= next_pos;
         end
      end
   end

endmodule

// >>> verilog/servo_software_limit_protection.v
/*
 * Software position-limit protection of a servo driver, plus the
 * scale, motor-match and self-diagnosis protection codes.
 * Assumes all inputs are synchronous to clk_sys_i; motor position and
 * command deltas are signed 32-bit encoder counts.
 */
`include "soft_limit_regs.vh"

module servo_software_limit_protection (
   input wire clk_sys_i,
   input wire reset_n_i,
   input wire servo_on_i,
   input wire [`MODE_W-1:0] control_mode_select_i,
   input wire [`MARGIN_W-1:0] limit_margin_setting_i,
   input wire [`ACT_W-1:0] error_response_action_i,
   input wire trial_run_i,
   input wire freq_measure_i,
   input wire homing_done_i,
   input wire autotune_start_i,
   input wire autotune_end_i,
   input wire cmd_valid_i,
   input wire signed [`CNT_MSB:0] cmd_delta_i,
   input wire signed [`CNT_MSB:0] motor_pos_i,
   input wire alarm_clear_i,
   input wire scale_unsupported_i,
   input wire motor_mismatch_i,
   input wire self_diag_fault_i,
   output reg range_exceeded_alarm_o,
   output reg [`CODE_W-1:0] alarm_code_o,
   output reg alarm_o,
   output reg stop_req_o,
   output reg [`ACT_W-1:0] stop_action_o,
   output reg protect_active_o,
   output reg protect_valid_o
);

   reg armed_q;
   reg invalid_q;
   reg signed [`POS_MSB:0] ref_pos_q;
   reg range_alarm_q;
   reg [`CODE_W-1:0] code_d;

   wire signed [`POS_MSB:0] cmd_pos;
   wire signed [`POS_MSB:0] low;
   wire signed [`POS_MSB:0] high;
   wire [`CODE_W-1:0] fault_code;
   wire fault;

   wire mode_ok;
   wire enabled;
   wire clear_range;
   wire signed [`POS_MSB:0] margin_w;
   wire signed [`POS_MSB:0] motor_w;
   wire signed [`POS_MSB:0] low_lim;
   wire signed [`POS_MSB:0] high_lim;
   wire signed [`POS_MSB:0] span_low;
   wire signed [`POS_MSB:0] span_high;
   wire over_bound;
   wire active;
   wire outside;

   assign mode_ok = (control_mode_select_i == `MODE_POSITION) ||
      (control_mode_select_i == `MODE_FULL_CLOSED);
   assign enabled = servo_on_i && (limit_margin_setting_i != 0);

   // reset covers power-up; these are the other clearing events
   assign clear_range = !enabled || homing_done_i || autotune_start_i ||
      autotune_end_i;

   assign margin_w = {{(`POS_W-`MARGIN_W){1'b0}}, limit_margin_setting_i};
   assign motor_w = {{2{motor_pos_i[`CNT_MSB]}}, motor_pos_i};

   // limits relative to the reference point taken when the range cleared;
   // with no commands low and high stay zero, giving margin either side
   assign low_lim = ref_pos_q + low - margin_w;
   assign high_lim = ref_pos_q + high + margin_w;

   assign span_low = margin_w - low;
   assign span_high = high + margin_w;
   assign over_bound = (span_low > `RANGE_BOUND) ||
      (span_high > `RANGE_BOUND);

   assign active = armed_q && mode_ok && enabled && !invalid_q &&
      !over_bound && !trial_run_i && !freq_measure_i;

   assign outside = (motor_w < low_lim) || (motor_w > high_lim);

   range_tracker u_range (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .clear_i(clear_range),
      .cmd_valid_i(cmd_valid_i && enabled),
      .cmd_delta_i(cmd_delta_i),
      .cmd_pos_o(cmd_pos),
      .low_o(low),
      .high_o(high)
   );

   fault_coder u_faults (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .alarm_clear_i(alarm_clear_i),
      .scale_unsupported_i(scale_unsupported_i),
      .motor_mismatch_i(motor_mismatch_i),
      .self_diag_fault_i(self_diag_fault_i),
      .fault_code_o(fault_code),
      .fault_o(fault)
   );

   // reference point captured while the range is cleared, so an idle
   // servo-on window centres on the present motor position
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ref_pos_q <= `POS_ZERO;
         armed_q <= 1'b0;
         invalid_q <= 1'b0;
      end else if (clear_range) begin
         ref_pos_q <= motor_w;
         armed_q <= 1'b0;
         invalid_q <= 1'b0;
      end else begin
         armed_q <= 1'b1;
         if (over_bound) begin
            invalid_q <= 1'b1;
         end
      end
   end

   // trip latches until software clears; a new trip beats the clear
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         range_alarm_q <= 1'b0;
      end else if (active && outside) begin
         range_alarm_q <= 1'b1;
      end else if (alarm_clear_i) begin
         range_alarm_q <= 1'b0;
      end
   end

   always @* begin
      code_d = fault_code;
      if (range_alarm_q && !fault) begin
         code_d = `CODE_SOFT_LIMIT;
      end
   end

   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         range_exceeded_alarm_o <= 1'b0;
         alarm_code_o <= `CODE_NONE;
         alarm_o <= 1'b0;
         stop_req_o <= 1'b0;
         stop_action_o <= {`ACT_W{1'b0}};
         protect_active_o <= 1'b0;
         protect_valid_o <= 1'b0;
      end else begin
         range_exceeded_alarm_o <= range_alarm_q;
         alarm_code_o <= code_d;
         alarm_o <= range_alarm_q || fault;
         stop_req_o <= range_alarm_q || fault;
         if (!(range_alarm_q || fault)) begin
            // action frozen at the trip so the stop cannot change mid-way
            stop_action_o <= error_response_action_i;
         end
         protect_active_o <= active;
         protect_valid_o <= !invalid_q && !over_bound;
      end
   end

endmodule

// >>> verilog/soft_limit_regs.vh
/*
 * Constants for the software position-limit protection: alarm codes,
 * control mode values, widths and setting sizes.
 * Assumes inclusion by bare name from every design file that needs them.
 */
`ifndef SOFT_LIMIT_REGS_VH
`define SOFT_LIMIT_REGS_VH

`define POS_W 34
`define POS_MSB 33
`define CNT_W 32
`define CNT_MSB 31
`define MARGIN_W 16
`define MODE_W 4
`define ACT_W 2
`define CODE_W 8

`define MODE_POSITION 4'h0
`define MODE_FULL_CLOSED 4'h6

`define CODE_NONE 8'h00
`define CODE_SOFT_LIMIT 8'h22
`define CODE_SCALE_TYPE 8'h5d
`define CODE_MOTOR_MATCH 8'h5f
// generic code for self-diagnosis faults; value is arbitrary
`define CODE_OTHER 8'hff

`define RANGE_BOUND 34'h0_7fff_ffff
`define POS_ZERO 34'h0_0000_0000

`endif
